/* inc/fos_regs.vh */
// Register map and timing constants of the fail output and reset supervisor
// How it works
// - Pin configuration writable only in Normal mode
// - Wake pin stays in Restart, off Fail-Safe
// - Switch pins disabled in Restart and Fail-Safe
// - Failure-activated fail output stays through Restart
// - Blink output toggles 1.25 Hz, 50 percent
// - Pulsed output 100 Hz, adjustable duty
// - Strap sampled at init, filtered 64 us
// - Reset low after filter, held plus delay
// - Power-up reset released after supply good plus delay
// - Watchdog failure also asserts reset
// - Undervoltage threshold select, defaults first level
// - Mode 11 in Normal/Stop: soft reset
// - Soft reset asserts reset output by default
// - Option cleared: soft reset without reset output
// - Soft reset ignored outside Normal/Stop
// - All three fail outputs activate together
// - Duty select 20, 10, 5, 2.5 percent
// - Fail outputs cleared after conditions end and clear
`ifndef FOS_REGS_VH
`define FOS_REGS_VH
// Register byte offsets
`define FOS_MODE_CTRL_OFF 8'h00
`define FOS_PIN_CFG_OFF 8'h04
`define FOS_FAIL_CTRL_OFF 8'h08
`define FOS_STATUS_OFF 8'h0C
// Mode codes (mode field of mode control)
`define FOS_MODE_NORMAL 2'h0
`define FOS_MODE_SLEEP 2'h1
`define FOS_MODE_STOP 2'h2
`define FOS_MODE_SOFT_RESET 2'h3
// Pin configuration codes
`define FOS_CFG_FAIL 3'h0
`define FOS_CFG_OFF 3'h1
`define FOS_CFG_WAKE 3'h2
`define FOS_CFG_LOW 3'h3
`define FOS_CFG_HIGH 3'h4
// Field positions
`define FOS_MODE_LSB 0
`define FOS_SRRO_BIT 2
`define FOS_UVTH_LSB 4
`define FOS_CFG2_LSB 0
`define FOS_CFG3_LSB 4
`define FOS_DUTY_LSB 8
`define FOS_FAILURE_BIT 0
`define FOS_TEST_ON_BIT 1
// Reset values
`define FOS_MODE_CTRL_RST 32'h0000_0004
`define FOS_PIN_CFG_RST 32'h0000_0000
`define FOS_FAIL_CTRL_RST 32'h0000_0000
// Timing, clock 250 MHz
`define FOS_CLK_HZ 250000000
`define FOS_BLINK_MHZ 1250
`define FOS_PULSE_HZ 100
`define FOS_STRAP_US 64
`define FOS_BLINK_HALF ((`FOS_CLK_HZ / 2) * 1000 / `FOS_BLINK_MHZ)
`define FOS_PULSE_PERIOD (`FOS_CLK_HZ / `FOS_PULSE_HZ)
`define FOS_STRAP_CYC (`FOS_STRAP_US * (`FOS_CLK_HZ / 1000000))
`define FOS_FILTER_US 10
`define FOS_FILTER_CYC (`FOS_FILTER_US * (`FOS_CLK_HZ / 1000000))
`define FOS_DELAY_US 10000
`define FOS_DELAY_CYC (`FOS_DELAY_US * (`FOS_CLK_HZ / 1000000))
`endif

/* design/fos_wave.v */
// Blink and pulsed waveform generator for the fail outputs
`include "fos_regs.vh"
module fos_wave #(
    parameter [31:0] BLINK_HALF = `FOS_BLINK_HALF,
    parameter [31:0] PULSE_PERIOD = `FOS_PULSE_PERIOD
) (
    input wire aclk, // Clock
    input wire aresetn, // Sync reset, low
    input wire run, // Waveforms enabled
    input wire [1:0] duty_sel, // Pulsed duty select
    output reg blink_on, // Blink phase active
    output reg pulse_on // Pulse phase active
);
    reg [31:0] blink_cnt_q;
    reg [31:0] pulse_cnt_q;
    reg [31:0] pulse_high;

    // Duty 20/10/5/2.5 percent of the period
    always @* begin
        case (duty_sel)
            2'h0: pulse_high = PULSE_PERIOD / 5;
            2'h1: pulse_high = PULSE_PERIOD / 10;
            2'h2: pulse_high = PULSE_PERIOD / 20;
            2'h3: pulse_high = PULSE_PERIOD / 40;
            default: pulse_high = PULSE_PERIOD / 5;
        endcase
    end

    // Counters restart when idle so each activation starts in the on phase
    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            blink_cnt_q <= 32'h0000_0000;
            pulse_cnt_q <= 32'h0000_0000;
            blink_on <= 1'b0;
            pulse_on <= 1'b0;
        end else begin
            if (blink_cnt_q >= BLINK_HALF * 2 - 1)
                blink_cnt_q <= 32'h0000_0000;
            else
                blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
            blink_on <= (blink_cnt_q < BLINK_HALF);
            if (pulse_cnt_q >= PULSE_PERIOD - 1)
                pulse_cnt_q <= 32'h0000_0000;
            else
                pulse_cnt_q <= pulse_cnt_q + 32'h0000_0001;
            pulse_on <= (pulse_cnt_q < pulse_high);
        end
    end
endmodule // fos_wave

/* design/fos_top.v */
// Fail output, pin configuration and reset output supervisor with AXI4-Lite
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`include "fos_regs.vh"
module fos_top #(
    parameter [31:0] DELAY_CYC = `FOS_DELAY_CYC,
    parameter [31:0] STRAP_CYC = `FOS_STRAP_CYC,
    parameter [31:0] FILTER_CYC = `FOS_FILTER_CYC,
    parameter [31:0] BLINK_HALF = `FOS_BLINK_HALF,
    parameter [31:0] PULSE_PERIOD = `FOS_PULSE_PERIOD
) (
    input wire aclk, // 250 MHz clock
    input wire aresetn, // Sync reset, low
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire restart_mode, // Device in Restart mode
    input wire failsafe_mode, // Device in Fail-Safe mode
    input wire init_mode, // Device in Init mode
    input wire fail_cond, // Failure condition present
    input wire supply_low, // Main supply below threshold
    input wire wd_fail, // Watchdog trigger failure
    input wire strap_in, // Pulsed fail pin level
    output reg static_fail_out_n, // Static fail output, low active
    output reg blink_fail_out_n, // Blink fail output, low active
    output reg pulsed_fail_out_strap_n, // Pulsed fail output, low active
    output reg pin2_oe, // Pin 2 switch drive enable
    output reg pin2_out, // Pin 2 switch level
    output reg pin3_oe, // Pin 3 switch drive enable
    output reg pin3_out, // Pin 3 switch level
    output reg pin2_wake_en, // Pin 2 wake detection on
    output reg pin3_wake_en, // Pin 3 wake detection on
    output reg dev_mode, // Development mode strap result
    output reg reset_out_n, // Reset output to host, low active
    output reg soft_reset_pulse, // Soft reset request, one cycle
    output reg [1:0] uv_threshold // Undervoltage threshold select
);
    reg [31:0] mode_ctrl_q;
    reg [31:0] pin_cfg_q;
    reg [31:0] fail_ctrl_q;
    reg [31:0] wr_val;
    reg aw_hold_q, w_hold_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg s1_q, s2_q, f1_q, f2_q, c1_q, c2_q, w1_q, w2_q;
    reg [31:0] strap_cnt_q;
    reg strap_done_q;
    reg [31:0] filt_cnt_q;
    reg [31:0] dly_cnt_q;
    reg rst_cond_q;
    reg soft_ro_q;
    reg fail_act_q;
    reg fo_active_q;
    wire blink_on, pulse_on;
    wire [1:0] mode = mode_ctrl_q[`FOS_MODE_LSB+1:`FOS_MODE_LSB];
    wire normal = (mode == `FOS_MODE_NORMAL) && !restart_mode && !failsafe_mode && !init_mode;
    wire stop = (mode == `FOS_MODE_STOP) && !restart_mode && !failsafe_mode && !init_mode;
    wire do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire [2:0] cfg2 = pin_cfg_q[`FOS_CFG2_LSB+2:`FOS_CFG2_LSB];
    wire [2:0] cfg3 = pin_cfg_q[`FOS_CFG3_LSB+2:`FOS_CFG3_LSB];
    wire soft_req = do_wr && (awaddr_q == `FOS_MODE_CTRL_OFF) && wstrb_q[0]
        && (wdata_q[`FOS_MODE_LSB+1:`FOS_MODE_LSB] == `FOS_MODE_SOFT_RESET);
    wire soft_ok = soft_req && (normal || stop);
    wire fo_active = fail_act_q || fail_ctrl_q[`FOS_TEST_ON_BIT];
    wire fs = restart_mode || failsafe_mode;

    // Byte-lane merge of write data into an old register value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (st[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // Pin inputs through two flops before use
    always @(posedge aclk) begin
        s1_q <= strap_in;
        s2_q <= s1_q;
        f1_q <= fail_cond;
        f2_q <= f1_q;
        c1_q <= supply_low;
        c2_q <= c1_q;
        w1_q <= wd_fail;
        w2_q <= w1_q;
    end

    // AXI write path: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q[7:2] <= 6'h3) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Candidate value for the addressed register
    always @* begin
        case (awaddr_q)
            `FOS_MODE_CTRL_OFF: wr_val = merge(mode_ctrl_q, wdata_q, wstrb_q);
            `FOS_PIN_CFG_OFF: wr_val = merge(pin_cfg_q, wdata_q, wstrb_q);
            `FOS_FAIL_CTRL_OFF: wr_val = merge(fail_ctrl_q, wdata_q, wstrb_q);
            default: wr_val = 32'h0000_0000;
        endcase
    end

    // Register file; soft reset restores every register
    always @(posedge aclk) begin
        if (!aresetn || soft_ok) begin
            mode_ctrl_q <= `FOS_MODE_CTRL_RST;
            pin_cfg_q <= `FOS_PIN_CFG_RST;
            fail_ctrl_q <= `FOS_FAIL_CTRL_RST;
        end else if (do_wr) begin
            if (awaddr_q == `FOS_MODE_CTRL_OFF && !soft_req)
                mode_ctrl_q <= wr_val & 32'h0000_0037;
            if (awaddr_q == `FOS_PIN_CFG_OFF && normal)
                pin_cfg_q <= wr_val & 32'h0000_0377;
            if (awaddr_q == `FOS_FAIL_CTRL_OFF)
                fail_ctrl_q <= wr_val & 32'h0000_0002;
        end
    end

    // Failure latch: hardware set wins over software clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            fail_act_q <= 1'b0;
        end else if (f2_q) begin
            fail_act_q <= 1'b1;
        end else if (do_wr && awaddr_q == `FOS_FAIL_CTRL_OFF && wstrb_q[0]
            && wdata_q[`FOS_FAILURE_BIT] && normal) begin
            fail_act_q <= 1'b0;
        end
    end

    // AXI read path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `FOS_MODE_CTRL_OFF: s_axi_rdata <= mode_ctrl_q;
                    `FOS_PIN_CFG_OFF: s_axi_rdata <= pin_cfg_q;
                    `FOS_FAIL_CTRL_OFF: s_axi_rdata <= fail_ctrl_q | {31'h0, fail_act_q};
                    `FOS_STATUS_OFF: s_axi_rdata <= {28'h0, dev_mode, !reset_out_n, f2_q, fail_act_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Development strap: filtered while in Init mode
    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_cnt_q <= 32'h0000_0000;
            strap_done_q <= 1'b0;
            dev_mode <= 1'b0;
        end else if (init_mode && !strap_done_q) begin
            if (s2_q) begin
                strap_cnt_q <= 32'h0000_0000;
            end else if (strap_cnt_q >= STRAP_CYC - 1) begin
                dev_mode <= 1'b1;
                strap_done_q <= 1'b1;
            end else begin
                strap_cnt_q <= strap_cnt_q + 32'h0000_0001;
            end
        end else if (!init_mode) begin
            strap_done_q <= 1'b0;
            strap_cnt_q <= 32'h0000_0000;
        end
    end

    // Reset output: filter, hold, then delay restarted at condition end
    always @(posedge aclk) begin
        if (!aresetn) begin
            filt_cnt_q <= 32'h0000_0000;
            dly_cnt_q <= 32'h0000_0000;
            rst_cond_q <= 1'b1;
            soft_ro_q <= 1'b0;
            reset_out_n <= 1'b0;
        end else begin
            if (soft_ok && mode_ctrl_q[`FOS_SRRO_BIT])
                soft_ro_q <= 1'b1;
            else
                soft_ro_q <= 1'b0;
            if (w2_q || soft_ro_q) begin
                rst_cond_q <= 1'b1;
            end else if (c2_q) begin
                if (filt_cnt_q >= FILTER_CYC - 1)
                    rst_cond_q <= 1'b1;
                else
                    filt_cnt_q <= filt_cnt_q + 32'h0000_0001;
            end else begin
                filt_cnt_q <= 32'h0000_0000;
                rst_cond_q <= 1'b0;
            end
            if (rst_cond_q) begin
                reset_out_n <= 1'b0;
                dly_cnt_q <= 32'h0000_0000;
            end else if (dly_cnt_q >= DELAY_CYC - 1) begin
                reset_out_n <= 1'b1;
            end else begin
                dly_cnt_q <= dly_cnt_q + 32'h0000_0001;
            end
        end
    end

    fos_wave #(.BLINK_HALF(BLINK_HALF), .PULSE_PERIOD(PULSE_PERIOD)) u_wave (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(fo_active),
        .duty_sel(pin_cfg_q[`FOS_DUTY_LSB+1:`FOS_DUTY_LSB]),
        .blink_on(blink_on),
        .pulse_on(pulse_on)
    );

    // Pin drive per configuration and device mode
    always @(posedge aclk) begin
        if (!aresetn) begin
            static_fail_out_n <= 1'b1;
            fo_active_q <= 1'b0;
            blink_fail_out_n <= 1'b1;
            pulsed_fail_out_strap_n <= 1'b1;
            pin2_oe <= 1'b0;
            pin2_out <= 1'b0;
            pin3_oe <= 1'b0;
            pin3_out <= 1'b0;
            pin2_wake_en <= 1'b0;
            pin3_wake_en <= 1'b0;
            soft_reset_pulse <= 1'b0;
            uv_threshold <= 2'h0;
        end else begin
            soft_reset_pulse <= soft_ok;
            uv_threshold <= mode_ctrl_q[`FOS_UVTH_LSB+1:`FOS_UVTH_LSB];
            // Extra stage matches the waveform generator, so all three switch together
            fo_active_q <= fo_active;
            static_fail_out_n <= !fo_active_q;
            blink_fail_out_n <= !(cfg2 == `FOS_CFG_FAIL && blink_on);
            pulsed_fail_out_strap_n <= !(cfg3 == `FOS_CFG_FAIL && pulse_on);
            pin2_wake_en <= (cfg2 == `FOS_CFG_WAKE) && !failsafe_mode;
            pin3_wake_en <= (cfg3 == `FOS_CFG_WAKE) && !failsafe_mode;
            pin2_oe <= (cfg2 == `FOS_CFG_LOW || cfg2 == `FOS_CFG_HIGH) && !fs;
            pin2_out <= (cfg2 == `FOS_CFG_HIGH) && !fs;
            pin3_oe <= (cfg3 == `FOS_CFG_LOW || cfg3 == `FOS_CFG_HIGH) && !fs;
            pin3_out <= (cfg3 == `FOS_CFG_HIGH) && !fs;
        end
    end
endmodule // fos_top

/* dv/fos_host_model.sv */
// Host-side model: strap pull-up and reset output observer
module fos_host_model (
    input logic reset_out_n, // Reset from supervisor
    input logic strap_low, // Pull strap pin low
    output logic strap_in, // Strap pin level
    output int reset_cnt // Reset releases seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board pull-up keeps the strap high unless a test pulls it low
    assign strap_in = strap_low ? 1'b0 : 1'b1;
    // Host leaves reset on each rising edge; count them
    initial reset_cnt = 0;
    always @(posedge reset_out_n) reset_cnt <= reset_cnt + 1;
endmodule // fos_host_model

/* dv/fos_chk_asserts.sv */
// Assertion checker for the fail output and reset supervisor
module fos_chk #(
    parameter [31:0] DELAY_CYC = 50
) (
    input logic aclk, // Clock
    input logic aresetn, // Sync reset, low
    input logic wd_fail, // Watchdog failure
    input logic supply_low, // Supply low
    input logic restart_mode, // Restart mode
    input logic failsafe_mode, // Fail-Safe mode
    input logic s_axi_bvalid, // Write response valid
    input logic s_axi_bready, // Write response ready
    input logic s_axi_rvalid, // Read valid
    input logic s_axi_rready, // Read ready
    input logic [31:0] s_axi_rdata, // Read data
    input logic static_fail_out_n, // Static fail
    input logic blink_fail_out_n, // Blink fail
    input logic pulsed_fail_out_strap_n, // Pulsed fail
    input logic pin2_oe, // Pin 2 drive
    input logic pin3_oe, // Pin 3 drive
    input logic pin2_wake_en, // Pin 2 wake
    input logic pin3_wake_en, // Pin 3 wake
    input logic reset_out_n, // Reset output
    input logic soft_reset_pulse, // Soft reset
    input logic [1:0] uv_threshold // Threshold select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] quiet_q;
    logic [31:0] quiet_d;
    // Cycles since every reset cause went away, saturating
    assign quiet_d = (wd_fail || supply_low || soft_reset_pulse) ? 32'h0 :
        quiet_q + ((quiet_q < 32'hFFFF) ? 32'h1 : 32'h0);
    always_ff @(posedge aclk) quiet_q <= aresetn ? quiet_d : 32'h0;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wd_held;
        wd_fail [*8];
    endsequence
    sequence s_blink_fall;
        $fell(blink_fail_out_n) && !static_fail_out_n;
    endsequence
    chk_wd_reset: assert property (s_wd_held |-> ##3 !reset_out_n)
        else $error("reset output not low on watchdog failure");
    // Slack of two for the soft reset path, which has no input sync
    chk_reset_stretch: assert property ($rose(reset_out_n) |-> quiet_q >= DELAY_CYC - 32'd2)
        else $error("reset released before the delay");
    chk_reset_release: assert property (quiet_q == DELAY_CYC + 32'd12 |-> reset_out_n)
        else $error("reset not released after the delay");
    chk_fail_group: assert property (static_fail_out_n |-> blink_fail_out_n && pulsed_fail_out_strap_n)
        else $error("fail outputs not switched together");
    chk_blink_half: assert property (s_blink_fall |=> (static_fail_out_n || $stable(blink_fail_out_n)) [*7])
        else $error("blink phase too short");
    chk_blink_turn: assert property (s_blink_fall ##8 !static_fail_out_n |-> blink_fail_out_n)
        else $error("blink phase too long");
    chk_pulse_width: assert property ($fell(pulsed_fail_out_strap_n) |-> ##[1:8] pulsed_fail_out_strap_n)
        else $error("pulsed low phase too long");
    chk_switch_off: assert property ((restart_mode || failsafe_mode) [*2] |-> !pin2_oe && !pin3_oe)
        else $error("switch driven in restart or fail-safe");
    chk_wake_off: assert property (failsafe_mode [*2] |-> !pin2_wake_en && !pin3_wake_en)
        else $error("wake enabled in fail-safe");
    chk_soft_once: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse longer than one cycle");
    chk_soft_default: assert property (soft_reset_pulse |-> ##[1:3] uv_threshold == 2'h0)
        else $error("soft reset kept threshold setting");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before ready");
endmodule // fos_chk

/* dv/tb.sv */
// Self-checking testbench of the fail output and reset supervisor
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 50;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, restart_mode = 1'b0, failsafe_mode = 1'b0, init_mode = 1'b1;
    logic fail_cond = 1'b0, supply_low = 1'b1, wd_fail = 1'b0, strap_low = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, strap_in;
    logic [1:0] s_axi_bresp, s_axi_rresp, uv_threshold, br;
    logic [31:0] s_axi_rdata;
    logic static_fail_out_n, blink_fail_out_n, pulsed_fail_out_strap_n, pin2_oe, pin2_out, pin3_oe;
    logic pin3_out, pin2_wake_en, pin3_wake_en, dev_mode, reset_out_n, soft_reset_pulse;
    int bad_count = 0, cmp_count = 0, reset_cnt, pl, bt, sp_cnt = 0;
    fos_top #(.DELAY_CYC(DLY), .STRAP_CYC(16), .FILTER_CYC(4), .BLINK_HALF(8), .PULSE_PERIOD(40)) dut (.*);
    fos_host_model host (.reset_out_n(reset_out_n), .strap_low(strap_low), .strap_in(strap_in),
        .reset_cnt(reset_cnt));
    always #2 aclk = ~aclk;
    // Soft reset pulses seen
    always @(posedge aclk) if (soft_reset_pulse === 1'b1) sp_cnt <= sp_cnt + 1;
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        cmp("rdata", e, s_axi_rdata);
        cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
    endtask
    // Low cycles of the pulsed output and toggles of the blink output
    task automatic meas(input int n);
        logic b;
        pl = 0;
        bt = 0;
        b = blink_fail_out_n;
        repeat (n) begin
            @(posedge aclk);
            pl += (pulsed_fail_out_strap_n === 1'b0);
            bt += (blink_fail_out_n !== b);
            b = blink_fail_out_n;
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        wait_cyc(2);
        aresetn <= 1'b1;
        wait_cyc(30);
        cmp("dev_mode", 1, dev_mode);
        cmp("reset_out_n", 0, reset_out_n);
        init_mode <= 1'b0;
        strap_low <= 1'b0;
        supply_low <= 1'b0;
        wait_cyc(DLY - 5);
        cmp("reset_out_n", 0, reset_out_n);
        wait_cyc(20);
        cmp("reset_out_n", 1, reset_out_n);
        rchk(8'h00, 32'h0000_0004, 2'h0);
        rchk(8'h04, 32'h0000_0000, 2'h0);
        rchk(8'h10, 32'h0000_0000, 2'h2);
        wr(8'h10, 32'h0000_0001);
        cmp("bresp", 2, br);
        wr(8'h00, 32'h0000_0024);
        cmp("bresp", 0, br);
        wait_cyc(2);
        cmp("uv", 2, uv_threshold);
        // Pin 2 wake, pin 3 low-side, then restart and fail-safe
        wr(8'h04, 32'h0000_0032);
        wait_cyc(3);
        cmp("wake2", 1, pin2_wake_en);
        cmp("oe3", 1, pin3_oe);
        cmp("out3", 0, pin3_out);
        restart_mode <= 1'b1;
        wait_cyc(3);
        cmp("oe3", 0, pin3_oe);
        cmp("wake2", 1, pin2_wake_en);
        restart_mode <= 1'b0;
        failsafe_mode <= 1'b1;
        wait_cyc(3);
        cmp("wake2", 0, pin2_wake_en);
        failsafe_mode <= 1'b0;
        wait_cyc(3);
        cmp("oe3", 1, pin3_oe);
        cmp("wake2", 1, pin2_wake_en);
        rchk(8'h04, 32'h0000_0032, 2'h0);
        wr(8'h04, 32'h0000_0034);
        wait_cyc(3);
        cmp("out2", 1, pin2_out & pin2_oe);
        // Stop mode keeps the configuration fixed
        wr(8'h00, 32'h0000_0026);
        wr(8'h04, 32'h0000_0000);
        rchk(8'h04, 32'h0000_0034, 2'h0);
        wr(8'h00, 32'h0000_0024);
        wr(8'h04, 32'h0000_0000);
        fail_cond <= 1'b1;
        wait_cyc(8);
        cmp("static", 0, static_fail_out_n);
        meas(64);
        cmp("blink toggles", 8, bt);
        meas(40);
        cmp("pulse lows", 8, pl);
        for (int k = 1; k < 4; k++) begin
            wr(8'h04, 32'(k) << 8);
            wait_cyc(40);
            meas(40);
            cmp("pulse lows", 32'(8 >> k), pl);
        end
        wr(8'h08, 32'h0000_0001);
        fail_cond <= 1'b0;
        wait_cyc(8);
        cmp("static", 0, static_fail_out_n);
        restart_mode <= 1'b1;
        wait_cyc(3);
        cmp("static", 0, static_fail_out_n);
        restart_mode <= 1'b0;
        rchk(8'h04, 32'h0000_0300, 2'h0);
        wr(8'h08, 32'h0000_0001);
        wait_cyc(3);
        cmp("fail outs", 3'b111, {static_fail_out_n, blink_fail_out_n, pulsed_fail_out_strap_n});
        // Watchdog failure: synchronized, held, then stretched
        wd_fail <= 1'b1;
        wait_cyc(2);
        cmp("reset_out_n", 1, reset_out_n);
        wait_cyc(10);
        cmp("reset_out_n", 0, reset_out_n);
        wd_fail <= 1'b0;
        wait_cyc(DLY - 5);
        cmp("reset_out_n", 0, reset_out_n);
        wait_cyc(20);
        cmp("releases", 2, reset_cnt);
        // Supply dip shorter than the filter, then a held one
        supply_low <= 1'b1;
        wait_cyc(3);
        supply_low <= 1'b0;
        wait_cyc(8);
        cmp("reset_out_n", 1, reset_out_n);
        supply_low <= 1'b1;
        wait_cyc(10);
        cmp("reset_out_n", 0, reset_out_n);
        supply_low <= 1'b0;
        wait_cyc(DLY + 20);
        cmp("releases", 3, reset_cnt);
        // Soft reset ignored in Sleep, quiet in Stop, asserting in Normal
        wr(8'h00, 32'h0000_0025);
        wr(8'h00, 32'h0000_0027);
        rchk(8'h00, 32'h0000_0025, 2'h0);
        wr(8'h00, 32'h0000_0022);
        wr(8'h00, 32'h0000_0023);
        wait_cyc(3);
        cmp("reset_out_n", 1, reset_out_n);
        cmp("uv", 0, uv_threshold);
        wr(8'h00, 32'h0000_0024);
        wr(8'h00, 32'h0000_0027);
        wait_cyc(3);
        cmp("reset_out_n", 0, reset_out_n);
        rchk(8'h00, 32'h0000_0004, 2'h0);
        wait_cyc(DLY + 20);
        cmp("releases", 4, reset_cnt);
        cmp("soft pulses", 2, sp_cnt);
        end_sim();
    end
    // Hang guard, well past the expected run length
    initial begin
        #100us;
        bad_count++;
        end_sim();
    end
endmodule // tb
bind fos_top fos_chk #(.DELAY_CYC(DELAY_CYC)) u_chk (.*);
